//--- pkg/palette_gate_pkg.sv
// Constants shared by the palette port and access gating block.
// Assumes an 8-bit host I/O data path with 16-bit port addresses.
package palette_gate_pkg;

	localparam int          IO_AW            = 16;
	localparam int          DATA_W           = 8;
	localparam int          IDX_W            = 8;
	localparam int          COMP_W           = 6;
	localparam int          ENTRY_W          = 3 * COMP_W;
	localparam int          PAL_DEPTH        = 256;
	localparam int          STATE_W          = 2;

	typedef logic [IO_AW-1:0]   io_addr_t;
	typedef logic [DATA_W-1:0]  io_data_t;
	typedef logic [IDX_W-1:0]   pal_index_t;
	typedef logic [COMP_W-1:0]  comp_t;
	typedef logic [ENTRY_W-1:0] entry_t;

	// Port addresses
	localparam io_addr_t    SETUP_ENABLE_ADDR = 16'h0102;
	localparam io_addr_t    ARMED_ENABLE_ADDR = 16'h03c3;
	localparam io_addr_t    EXT_INDEX_ADDR    = 16'h03c4;
	localparam io_addr_t    EXT_DATA_ADDR     = 16'h03c5;
	localparam io_addr_t    PAL_FIRST_ADDR    = 16'h03c6;
	localparam io_addr_t    PAL_READ_IDX_ADDR = 16'h03c7;
	localparam io_addr_t    PAL_WRITE_IDX_ADDR = 16'h03c8;
	localparam io_addr_t    PAL_DATA_ADDR     = 16'h03c9;

	// Extension register holding the arm flag
	localparam io_data_t    EXT_ARM_INDEX     = 8'hfc;
	localparam int          ARM_BIT           = 7;
	localparam int          ENABLE_BIT        = 0;

	// Reset values and fixed read-back bits
	localparam logic        ENABLE_RESET      = 1'b1;
	localparam logic        ARM_RESET         = 1'b0;
	localparam logic [6:0]  ARMED_UNUSED_BITS = 7'h7f;
	localparam logic [6:0]  SETUP_UNUSED_BITS = 7'h00;
	localparam io_data_t    IDLE_READ_DATA    = 8'hff;
	localparam io_data_t    ZERO_DATA         = 8'h00;
	localparam pal_index_t  INDEX_RESET       = 8'h00;
	localparam pal_index_t  INDEX_STEP        = 8'h01;
	localparam logic [STATE_W-1:0] STATE_RESET = 2'h0;

	// Position in the red, green, blue sequence
	typedef enum logic [2:0] {
		PH_RED   = 3'b001,
		PH_GREEN = 3'b010,
		PH_BLUE  = 3'b100
	} phase_e;

endpackage : palette_gate_pkg

//--- rtl/palette_store.sv
// Colour lookup store: 256 entries of 18 bits in flip-flops.
// Assumes one write port and a combinational read by index.
module palette_store
	import palette_gate_pkg::*;
(
	input  wire logic                        clock_i,    // Host bus clock
	input  wire logic                        rst_n_i,    // Async reset, active low
	input  wire logic                        wr_en_i,    // Write strobe
	input  wire palette_gate_pkg::pal_index_t wr_index_i, // Write entry
	input  wire palette_gate_pkg::entry_t    wr_entry_i, // Red, green, blue
	input  wire palette_gate_pkg::pal_index_t rd_index_i, // Read entry
	output palette_gate_pkg::entry_t         rd_entry_o  // Entry contents
);
	import palette_gate_pkg::*;

	entry_t store [PAL_DEPTH];

	for (genvar g = 0; g < PAL_DEPTH; g++) begin : g_entry
		always_ff @(posedge clock_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				store[g] <= '0;
			end else if (wr_en_i && (wr_index_i == IDX_W'(g))) begin
				store[g] <= wr_entry_i;
			end
		end
	end

	assign rd_entry_o = store[rd_index_i];

endmodule : palette_store

//--- rtl/palette_port_and_access_gating.sv
// Host I/O side of a display controller: palette port and access gating.
// Assumes one-cycle read and write strobes, never both at once.
// Assumes reads and writes at the data port share one phase.
//
// Overview of operation
// - Palette store holds 256 entries of three 6-bit colour components.
// - Each data byte carries its component in bits 5..0, top bits reserved.
// - Data port moves one entry as red, green, blue bytes in turn.
// - Index loads at write-index port for writes, read-index port for reads.
// - Current index reads back only at the write-index port.
// - Reads at the read-index port return the palette state readback.
// - Index advances by one after each full three-byte set.
// - Any index write restarts the component sequence at red.
// - State readback holds low address bits of last palette-range write.
// - Armed and enable bit clear blocks all but two enable ports.
// - While disarmed the armed enable port is ignored and holds.
// - Arm flag in extension register clears on reset.
// - Armed enable bit resets to one, upper bits read as ones.
// - In setup mode the setup enable bit gates host decoding.
// - Outside setup mode the setup enable port is ignored.
// - Setup enable bit resets to one, upper bits read as zeros.
// - In setup mode while armed, access needs both ports enabling; either alone disables.
// - Shutoff input high blocks every host access.
// - Blocked access leaves display running, protects memory and registers.
// - Blocked access also suppresses palette register accesses.
module palette_port_and_access_gating
	import palette_gate_pkg::*;
(
	input  wire logic                        clock_i,          // Host bus clock, 20 MHz
	input  wire logic                        rst_n_i,          // Async reset, active low
	input  wire palette_gate_pkg::io_addr_t  io_addr_i,        // I/O port address
	input  wire logic                        io_wr_i,          // I/O write strobe
	input  wire logic                        io_rd_i,          // I/O read strobe
	input  wire palette_gate_pkg::io_data_t  io_wdata_i,       // I/O write data
	input  wire logic                        setup_n_i,        // Setup mode, active low
	input  wire logic                        shutoff_i,        // External disable
	output palette_gate_pkg::io_data_t       io_rdata_o,       // Read data, next cycle
	output logic                             io_claim_o,       // Access was decoded
	output logic                             host_access_on_o  // Host memory/I/O allowed
);
	import palette_gate_pkg::*;

	function automatic comp_t pick_comp(input entry_t e, input phase_e p);
		unique case (p)
			PH_RED:   pick_comp = e[ENTRY_W-1 -: COMP_W];
			PH_GREEN: pick_comp = e[COMP_W +: COMP_W];
			PH_BLUE:  pick_comp = e[0 +: COMP_W];
			default:  pick_comp = '0;
		endcase
	endfunction : pick_comp

	// State registers
	logic               armed_enable;
	logic               setup_enable;
	logic               access_guard_arm;
	io_data_t           ext_index;
	pal_index_t         pal_index;
	phase_e             phase;
	comp_t              hold_red;
	comp_t              hold_green;
	logic [STATE_W-1:0] palette_state_readback;

	logic               next_armed_enable;
	logic               next_setup_enable;
	logic               next_access_guard_arm;
	io_data_t           next_ext_index;
	pal_index_t         next_pal_index;
	phase_e             next_phase;
	comp_t              next_hold_red;
	comp_t              next_hold_green;
	logic [STATE_W-1:0] next_palette_state_readback;
	io_data_t           next_io_rdata;
	logic               next_io_claim;
	logic               next_host_access_on;

	// Store interface
	logic               pal_wr_en;
	entry_t             pal_wr_entry;
	entry_t             pal_rd_entry;

	// Decode terms
	logic               any_access;
	logic               blocked;
	logic               open_decode;
	logic               hit_setup;
	logic               hit_armed;
	logic               hit_ext_index;
	logic               hit_ext_data;
	logic               hit_pal;
	comp_t              cur_comp;

	palette_store u_store (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.wr_en_i    (pal_wr_en),
		.wr_index_i (pal_index),
		.wr_entry_i (pal_wr_entry),
		.rd_index_i (pal_index),
		.rd_entry_o (pal_rd_entry)
	);

	always_comb begin
		any_access = io_wr_i | io_rd_i;
		blocked = shutoff_i
			| (!setup_n_i & !setup_enable)
			| (access_guard_arm & !armed_enable);
		open_decode = !blocked;
		// setup port reachable in setup mode
		hit_setup = any_access & (io_addr_i == SETUP_ENABLE_ADDR) & !shutoff_i & !setup_n_i;
		hit_armed = any_access & (io_addr_i == ARMED_ENABLE_ADDR) & !shutoff_i
			& access_guard_arm;
		hit_ext_index = any_access & open_decode & (io_addr_i == EXT_INDEX_ADDR);
		hit_ext_data  = any_access & open_decode & (io_addr_i == EXT_DATA_ADDR);
		hit_pal = any_access & open_decode
			& (io_addr_i >= PAL_FIRST_ADDR) & (io_addr_i <= PAL_DATA_ADDR);
		// Component of the current entry for this phase
		cur_comp = pick_comp(pal_rd_entry, phase);
	end

	always_comb begin
		next_armed_enable           = armed_enable;
		next_setup_enable           = setup_enable;
		next_access_guard_arm       = access_guard_arm;
		next_ext_index              = ext_index;
		next_pal_index              = pal_index;
		next_phase                  = phase;
		next_hold_red               = hold_red;
		next_hold_green             = hold_green;
		next_palette_state_readback = palette_state_readback;
		// Unclaimed reads return all ones
		next_io_rdata               = IDLE_READ_DATA;
		next_io_claim               = hit_setup | hit_armed | hit_ext_index
			| hit_ext_data | hit_pal;
		pal_wr_en                   = 1'b0;
		// Entry built from held red and green
		pal_wr_entry                = {hold_red, hold_green, io_wdata_i[COMP_W-1:0]};

		if (hit_setup) begin
			if (io_wr_i) begin
				next_setup_enable = io_wdata_i[ENABLE_BIT];
			end else begin
				next_io_rdata = {SETUP_UNUSED_BITS, setup_enable};
			end
		end

		if (hit_armed) begin
			if (io_wr_i) begin
				next_armed_enable = io_wdata_i[ENABLE_BIT];
			end else begin
				next_io_rdata = {ARMED_UNUSED_BITS, armed_enable};
			end
		end

		if (hit_ext_index) begin
			if (io_wr_i) begin
				next_ext_index = io_wdata_i;
			end else begin
				next_io_rdata = ext_index;
			end
		end

		if (hit_ext_data) begin
			if (ext_index == EXT_ARM_INDEX) begin
				if (io_wr_i) begin
					next_access_guard_arm = io_wdata_i[ARM_BIT];
				end else begin
					next_io_rdata = ZERO_DATA;
					next_io_rdata[ARM_BIT] = access_guard_arm;
				end
			end else if (io_rd_i) begin
				// Other indices read zero, writes dropped
				next_io_rdata = ZERO_DATA;
			end
		end

		if (hit_pal && io_wr_i) begin
			next_palette_state_readback = io_addr_i[STATE_W-1:0];
		end

		if (hit_pal) begin
			unique case (io_addr_i)
				PAL_READ_IDX_ADDR: begin
					if (io_wr_i) begin
						next_pal_index = io_wdata_i;
						next_phase     = PH_RED;
					end else begin
						next_io_rdata = {{(DATA_W-STATE_W){1'b0}}, palette_state_readback};
					end
				end
				PAL_WRITE_IDX_ADDR: begin
					if (io_wr_i) begin
						next_pal_index = io_wdata_i;
						next_phase     = PH_RED;
					end else begin
						next_io_rdata = pal_index;
					end
				end
				PAL_DATA_ADDR: begin
					if (io_rd_i) begin
						next_io_rdata = {{(DATA_W-COMP_W){1'b0}}, cur_comp};
					end
					unique case (phase)
						PH_RED: begin
							next_phase = PH_GREEN;
							if (io_wr_i) begin
								next_hold_red = io_wdata_i[COMP_W-1:0];
							end
						end
						PH_GREEN: begin
							next_phase = PH_BLUE;
							if (io_wr_i) begin
								next_hold_green = io_wdata_i[COMP_W-1:0];
							end
						end
						PH_BLUE: begin
							next_phase = PH_RED;
							// Blue write stores the entry
							pal_wr_en  = io_wr_i;
							next_pal_index = IDX_W'(pal_index + INDEX_STEP);
						end
						default: begin
							next_phase = PH_RED;
						end
					endcase
				end
				default: begin
					if (io_rd_i) begin
						next_io_rdata = ZERO_DATA;
					end
				end
			endcase
		end

		// Lags the enable state by one cycle
		next_host_access_on = !blocked;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Enable and arm state
			// armed enable resets on
			armed_enable           <= ENABLE_RESET;
			setup_enable           <= ENABLE_RESET;
			access_guard_arm       <= ARM_RESET;
			ext_index              <= ZERO_DATA;

			// Palette sequence state
			pal_index              <= INDEX_RESET;
			phase                  <= PH_RED;
			hold_red               <= '0;
			hold_green             <= '0;
			palette_state_readback <= STATE_RESET;

			// Registered outputs
			io_rdata_o             <= IDLE_READ_DATA;
			io_claim_o             <= 1'b0;
			host_access_on_o       <= 1'b1;
		end else begin
			// Enable and arm state
			armed_enable           <= next_armed_enable;
			setup_enable           <= next_setup_enable;
			access_guard_arm       <= next_access_guard_arm;
			ext_index              <= next_ext_index;

			// Palette sequence state
			pal_index              <= next_pal_index;
			phase                  <= next_phase;
			hold_red               <= next_hold_red;
			hold_green             <= next_hold_green;
			palette_state_readback <= next_palette_state_readback;

			// Registered outputs
			io_rdata_o             <= next_io_rdata;
			io_claim_o             <= next_io_claim;
			host_access_on_o       <= next_host_access_on;
		end
	end

endmodule : palette_port_and_access_gating

//--- bench/palette_gate_checker.sv
// Port checker for the palette port and access gating block.
// Assumes it is bound to the block's top module.
module palette_gate_checker
	import palette_gate_pkg::*;
(
	input wire logic                       clock_i,          // Clock
	input wire logic                       rst_n_i,          // Reset
	input wire palette_gate_pkg::io_addr_t io_addr_i,        // Address
	input wire logic                       io_wr_i,          // Write
	input wire logic                       io_rd_i,          // Read
	input wire palette_gate_pkg::io_data_t io_wdata_i,       // Write data
	input wire logic                       setup_n_i,        // Setup mode
	input wire logic                       shutoff_i,        // Disable
	input wire palette_gate_pkg::io_data_t io_rdata_o,       // Read data
	input wire logic                       io_claim_o,       // Claimed
	input wire logic                       host_access_on_o  // Access on
);
	timeunit 1ns;
	timeprecision 1ns;
	logic acc;
	assign acc = io_wr_i | io_rd_i;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_shut_claim; shutoff_i && acc |=> !io_claim_o; endproperty
	a_shut_claim: assert property (p_shut_claim) else $error("claim under shutoff");
	property p_shut_on; shutoff_i |=> !host_access_on_o; endproperty
	a_shut_on: assert property (p_shut_on) else $error("access on under shutoff");
	property p_setup_off; setup_n_i && acc && io_addr_i == 16'h0102 |=> !io_claim_o; endproperty
	a_setup_off: assert property (p_setup_off) else $error("setup port claimed");
	property p_armed_bits; io_rd_i && io_addr_i == 16'h03c3 |=> io_rdata_o[7:1] == 7'h7f;
	endproperty
	a_armed_bits: assert property (p_armed_bits) else $error("armed port high bits");
	property p_setup_bits; io_rd_i && io_addr_i == 16'h0102 |=> !io_claim_o ||
		io_rdata_o[7:1] == 7'h00; endproperty
	a_setup_bits: assert property (p_setup_bits) else $error("setup port high bits");
	property p_state_bits; io_rd_i && io_addr_i == 16'h03c7 |=> !io_claim_o ||
		io_rdata_o[7:2] == 6'h00; endproperty
	a_state_bits: assert property (p_state_bits) else $error("state high bits");
	property p_comp_bits; io_rd_i && io_addr_i == 16'h03c9 |=> !io_claim_o ||
		io_rdata_o[7:6] == 2'h0; endproperty
	a_comp_bits: assert property (p_comp_bits) else $error("component high bits");
	property p_state_val; io_wr_i && io_addr_i == 16'h03c7 ##1 io_claim_o && !acc ##1
		io_rd_i && io_addr_i == 16'h03c7 |=> !io_claim_o || io_rdata_o == 8'h03; endproperty
	a_state_val: assert property (p_state_val) else $error("state after read index");
	property p_block; acc && io_addr_i[15:1] == 15'h01e4 ##1 !host_access_on_o |->
		!io_claim_o; endproperty
	a_block: assert property (p_block) else $error("palette claimed while blocked");
	property p_pal_claim; acc && io_addr_i >= 16'h03c6 && io_addr_i <= 16'h03c9 ##1
		host_access_on_o |-> io_claim_o; endproperty
	a_pal_claim: assert property (p_pal_claim) else $error("palette not claimed while open");
endmodule : palette_gate_checker

bind palette_port_and_access_gating palette_gate_checker i_chk (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
	.io_wdata_i(io_wdata_i), .setup_n_i(setup_n_i), .shutoff_i(shutoff_i),
	.io_rdata_o(io_rdata_o), .io_claim_o(io_claim_o), .host_access_on_o(host_access_on_o));

//--- bench/palette_host_model.sv
// Host CPU model: one-cycle read and write strobes.
// Assumes tasks are entered after a clock edge, one at a time.
module palette_host_model
	import palette_gate_pkg::*;
(
	input  wire logic                       clock_i,    // Clock
	input  wire palette_gate_pkg::io_data_t io_rdata_i, // Read data
	output palette_gate_pkg::io_addr_t      io_addr_o,  // Address
	output logic                            io_wr_o,    // Write
	output logic                            io_rd_o,    // Read
	output palette_gate_pkg::io_data_t      io_wdata_o  // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		io_addr_o = 16'h0000;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end
	task automatic wr(input io_addr_t a, input io_data_t d);
		@(posedge clock_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_wr_o <= 1'b1;
		@(posedge clock_i);
		io_wr_o <= 1'b0;
		io_addr_o <= ~a;
		io_wdata_o <= ~d;
	endtask : wr
	task automatic rd(input io_addr_t a, output io_data_t d);
		@(posedge clock_i);
		io_addr_o <= a;
		io_rd_o <= 1'b1;
		@(posedge clock_i);
		io_rd_o <= 1'b0;
		io_addr_o <= ~a;
		#1;
		d = io_rdata_i;
	endtask : rd
endmodule : palette_host_model

//--- bench/palette_port_and_access_gating_bench.sv
// Bench for the palette port and access gating block.
// Assumes the host model and the checker are compiled first.
module palette_port_and_access_gating_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import palette_gate_pkg::*;
	logic     clock = 1'b0;
	logic     rst_n = 1'b0;
	logic     setup_n = 1'b0;
	logic     shutoff = 1'b0;
	logic     wr;
	logic     rd;
	logic     claim;
	logic     on;
	io_addr_t addr;
	io_data_t wdata;
	io_data_t rdata;
	int       n_fail = 0;
	int       n_checks = 0;
	always #25 clock = ~clock;
	palette_host_model i_host (.clock_i(clock), .io_rdata_i(rdata), .io_addr_o(addr),
		.io_wr_o(wr), .io_rd_o(rd), .io_wdata_o(wdata));
	palette_port_and_access_gating i_dut (.clock_i(clock), .rst_n_i(rst_n), .io_addr_i(addr),
		.io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .setup_n_i(setup_n),
		.shutoff_i(shutoff), .io_rdata_o(rdata), .io_claim_o(claim), .host_access_on_o(on));
	task automatic chk(input string what, input io_data_t exp, input io_data_t got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic rc(input io_addr_t a, input io_data_t exp, input string what);
		io_data_t d;
		i_host.rd(a, d);
		chk(what, exp, d);
	endtask : rc
	task automatic on_chk(input logic exp);
		repeat (2) @(posedge clock);
		#1;
		chk("access_on", {7'h00, exp}, {7'h00, on});
	endtask : on_chk
	task automatic pw(input io_data_t r, g, b);
		i_host.wr(16'h03c9, r);
		i_host.wr(16'h03c9, g);
		i_host.wr(16'h03c9, b);
	endtask : pw
	task automatic pr(input io_data_t r, g, b);
		rc(16'h03c9, r, "red");
		rc(16'h03c9, g, "green");
		rc(16'h03c9, b, "blue");
	endtask : pr
	task automatic final_report;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rc(16'h0102, 8'h01, "setup_en");
		rc(16'h03c8, 8'h00, "index");
		rc(16'h03c7, 8'h00, "state");
		$display("test reset done");
		i_host.wr(16'h03c8, 8'hff);
		pw(8'hff, 8'h55, 8'hea);
		rc(16'h03c8, 8'h00, "index");
		pw(8'h01, 8'h02, 8'h03);
		rc(16'h03c8, 8'h01, "index");
		i_host.wr(16'h03c7, 8'hff);
		rc(16'h03c7, 8'h03, "state");
		pr(8'h3f, 8'h15, 8'h2a);
		pr(8'h01, 8'h02, 8'h03);
		rc(16'h03c8, 8'h01, "index");
		$display("test palette done");
		i_host.wr(16'h03c8, 8'h05);
		i_host.wr(16'h03c9, 8'h11);
		i_host.wr(16'h03c9, 8'h22);
		i_host.wr(16'h03c8, 8'h05);
		rc(16'h03c7, 8'h00, "state");
		pw(8'h0a, 8'h0b, 8'h0c);
		i_host.wr(16'h03c7, 8'h05);
		rc(16'h03c9, 8'h0a, "red");
		i_host.wr(16'h03c7, 8'h05);
		pr(8'h0a, 8'h0b, 8'h0c);
		$display("test abort done");
		@(posedge clock);
		setup_n <= 1'b1;
		i_host.wr(16'h0102, 8'h00);
		on_chk(1'b1);
		rc(16'h0102, 8'hff, "setup_en");
		@(posedge clock);
		setup_n <= 1'b0;
		i_host.wr(16'h0102, 8'h00);
		on_chk(1'b0);
		rc(16'h03c8, 8'hff, "index");
		rc(16'h0102, 8'h00, "setup_en");
		i_host.wr(16'h0102, 8'h01);
		on_chk(1'b1);
		$display("test setup done");
		i_host.wr(16'h03c3, 8'h00);
		on_chk(1'b1);
		i_host.wr(16'h03c4, 8'hfc);
		i_host.wr(16'h03c5, 8'h80);
		rc(16'h03c3, 8'hff, "armed_en");
		i_host.wr(16'h03c3, 8'h00);
		on_chk(1'b0);
		rc(16'h03c3, 8'hfe, "armed_en");
		rc(16'h03c9, 8'hff, "red");
		rc(16'h0102, 8'h01, "setup_en");
		i_host.wr(16'h03c3, 8'h01);
		on_chk(1'b1);
		$display("test arm done");
		@(posedge clock);
		shutoff <= 1'b1;
		on_chk(1'b0);
		rc(16'h0102, 8'hff, "setup_en");
		i_host.wr(16'h03c8, 8'h77);
		@(posedge clock);
		shutoff <= 1'b0;
		on_chk(1'b1);
		rc(16'h03c8, 8'h06, "index");
		$display("test shutoff done");
		final_report();
	end
	initial begin
		repeat (2000) @(posedge clock);
		n_fail++;
		final_report();
	end
endmodule : palette_port_and_access_gating_bench
